// ### hw/icn_ctrl.sv
/*
 Command handling, NVM image load and program, retrim flow, error reporting
 and register bank with burst shadowing and clear-on-read.
 Assumes a synchronous byte register port with read data one cycle later,
 an external NVM array of 16 bytes reached through a simple word port, and
 sensor/motion/error inputs from the datapath outside.
*/
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
`include "icn_regs.svh"
module icn_ctrl
   import icn_pkg::*;
#(
   parameter int BOOT_CYC = `ICN_BOOT_NS / `ICN_CLK_NS,
   parameter int PROG_CYC = `ICN_PROG_NS / `ICN_CLK_NS,
   parameter int CRT_CYC = `ICN_CRT_NS / `ICN_CLK_NS,
   parameter int NV_DEPTH = 16
)
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_burst,
   input wire logic [7:0] i_nvm_rdata,
   input wire logic [7:0] i_sensor_data [0:23],
   input wire logic [7:0] i_feature_data [0:15],
   input wire logic i_motion,
   input wire logic i_crt_fail,
   input wire logic [7:0] i_hw_err,
   input wire logic [7:0] i_int_stat0,
   input wire logic [7:0] i_int_stat1,
   input wire logic i_drdy_acc,
   input wire logic i_drdy_gyr,
   input wire logic [10:0] i_crt_gain,
   output logic [7:0] o_rdata,
   output logic [3:0] o_nvm_addr,
   output logic [7:0] o_nvm_wdata,
   output logic o_nvm_we,
   output logic o_int1,
   output logic o_int2,
   output logic o_gyr_start,
   output logic [10:0] o_gyr_gain
);
   localparam int AW = $clog2(BOOT_CYC + PROG_CYC + CRT_CYC + 2);

   icn_state_e state;
   logic [AW-1:0] timer;
   logic [3:0] nv_idx;
   icn_byte_t nv_img [0:NV_DEPTH-1];
   icn_byte_t err_reg, event_reg, ist0, ist1, err_mask, int_map;
   icn_byte_t accel_config_register, gyro_config_register, gen_set, g_trig, pwr_conf, pwr_ctrl;
   logic [2:0] gain_status;
   logic crt_running, nvm_prog_en, drdy_acc, drdy_gyr;
   logic [10:0] gain_new, gain_live;
   logic gain_pending, gyr_en_q;
   icn_byte_t shadow [0:39];
   logic shadow_live;
   logic busy, wr_ok, rd_ok, soft_rst, in_main, in_feat;
   icn_byte_t status_byte, next_rdata;

   assign busy = (state != ICN_IDLE) && (state != ICN_CRT);
   assign wr_ok = i_wr && !busy;
   assign rd_ok = i_rd && !busy;
   assign soft_rst = i_wr && (i_addr == `ICN_A_CMD) && (i_wdata == `ICN_CMD_SOFTRESET)
      && (state != ICN_BOOT);
   assign in_main = (i_addr >= `ICN_A_STATUS) && (i_addr <= `ICN_A_FIFO_LEN_LAST);
   assign in_feat = (i_addr >= `ICN_A_FEAT_FIRST) && (i_addr <= `ICN_A_FEAT_LAST);

   always_comb
   begin
      status_byte = 8'h00;
      status_byte[`ICN_B_CMD_RDY] = !busy;
      status_byte[`ICN_B_DRDY_ACC] = drdy_acc;
      status_byte[`ICN_B_DRDY_GYR] = drdy_gyr;
   end

   // Sequencer: boot load, idle, retrim run, NVM program
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || soft_rst)
      begin
         state <= ICN_BOOT;
         timer <= '0;
         nv_idx <= 4'h0;
      end
      else
      begin
         unique case (state)
            ICN_BOOT:
            begin
               nv_idx <= nv_idx + 4'h1;
               timer <= timer + 1'b1;
               if (timer >= AW'(BOOT_CYC - 1))
                  state <= ICN_IDLE;
            end
            ICN_IDLE:
            begin
               timer <= '0;
               if (wr_ok && i_addr == `ICN_A_CMD && i_wdata == `ICN_CMD_G_TRIGGER
                  && crt_running && g_trig[`ICN_B_TRIG_SELECT]
                  && !g_trig[`ICN_B_TRIG_BLOCK])
                  state <= ICN_CRT;
               else if (wr_ok && i_addr == `ICN_A_CMD && i_wdata == `ICN_CMD_PROG_NVM
                  && nvm_prog_en && !pwr_conf[`ICN_B_AUTOSAVE]
                  && gen_set[`ICN_B_NVM_PREP])
                  state <= ICN_PROG;
            end
            ICN_CRT:
            begin
               timer <= timer + 1'b1;
               if (i_motion || timer >= AW'(CRT_CYC - 1))
                  state <= ICN_IDLE;
            end
            ICN_PROG:
            begin
               nv_idx <= nv_idx + 4'h1;
               timer <= timer + 1'b1;
               if (timer >= AW'(PROG_CYC - 1))
                  state <= ICN_IDLE;
            end
         endcase
      end
   end

   // NVM port: whole image streamed out during a program cycle
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         o_nvm_addr <= 4'h0;
         o_nvm_wdata <= 8'h00;
         o_nvm_we <= 1'b0;
      end
      else
      begin
         o_nvm_addr <= nv_idx;
         o_nvm_wdata <= nv_img[nv_idx];
         o_nvm_we <= (state == ICN_PROG) && (timer < AW'(NV_DEPTH));
      end
   end

   // Image registers; the index follows the registered NVM address by the array latency
   logic [3:0] load_idx;
   logic load_q;
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         load_idx <= 4'h0;
         load_q <= 1'b0;
      end
      else
      begin
         load_idx <= o_nvm_addr;
         load_q <= (state == ICN_BOOT) && !soft_rst;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (load_q)
         nv_img[load_idx] <= i_nvm_rdata;
      else if (wr_ok && i_addr >= `ICN_A_NV_FIRST && i_addr <= `ICN_A_NV_LAST)
         nv_img[4'(i_addr - `ICN_A_NV_FIRST)] <= i_wdata;
      else if (state == ICN_CRT && !i_motion && !i_crt_fail && timer >= AW'(CRT_CYC - 1))
         nv_img[4'(`ICN_A_OFFSET6 - `ICN_A_NV_FIRST)][`ICN_B_GAIN_EN] <= 1'b1;
   end

   assign nvm_prog_en = nv_img[4'(`ICN_A_NVM_CONF - `ICN_A_NV_FIRST)][`ICN_B_NVM_PROG_EN];

   // Ordinary control registers
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || soft_rst || state == ICN_BOOT)
      begin
         err_mask <= 8'h00;
         int_map <= 8'h00;
         accel_config_register <= `ICN_RST_ACCEL_CONFIG_REGISTER;
         gyro_config_register <= `ICN_RST_GYRO_CONFIG_REGISTER;
         gen_set <= 8'h00;
         g_trig <= 8'h00;
         pwr_conf <= `ICN_RST_PWR_CONF;
         pwr_ctrl <= 8'h00;
      end
      else if (wr_ok)
      begin
         unique case (i_addr)
            `ICN_A_ERR_MASK: err_mask <= i_wdata;
            `ICN_A_INT_MAP: int_map <= i_wdata;
            `ICN_A_ACCEL_CONFIG_REGISTER: accel_config_register <= i_wdata;
            `ICN_A_GYRO_CONFIG_REGISTER: gyro_config_register <= i_wdata;
            `ICN_A_GEN_SET: gen_set <= i_wdata;
            `ICN_A_G_TRIG: g_trig <= i_wdata;
            `ICN_A_PWR_CONF: pwr_conf <= i_wdata;
            `ICN_A_PWR_CTRL: pwr_ctrl <= i_wdata;
            default: ;
         endcase
      end
   end

   // Retrim flag and status
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || soft_rst || state == ICN_BOOT)
      begin
         crt_running <= 1'b0;
         gain_status <= `ICN_GAIN_OK;
         gain_new <= 11'h400;
         gain_pending <= 1'b0;
      end
      else if (state == ICN_CRT)
      begin
         if (i_motion)
         begin
            crt_running <= 1'b0;
            gain_status <= `ICN_GAIN_ABORT;
         end
         else if (timer >= AW'(CRT_CYC - 1))
         begin
            crt_running <= 1'b0;
            gain_status <= i_crt_fail ? `ICN_GAIN_EXEC_ERR : `ICN_GAIN_OK;
            if (!i_crt_fail)
            begin
               gain_new <= i_crt_gain;
               gain_pending <= 1'b1;
            end
         end
      end
      else
      begin
         if (wr_ok && i_addr == `ICN_A_CRT_CONF)
            crt_running <= i_wdata[`ICN_B_CRT_RUNNING];
         if (o_gyr_start)
            gain_pending <= 1'b0;
      end
   end

   // Gain applied on the rising edge of gyro enable
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         gyr_en_q <= 1'b0;
         o_gyr_start <= 1'b0;
         gain_live <= 11'h400;
         o_gyr_gain <= 11'h400;
      end
      else
      begin
         gyr_en_q <= pwr_ctrl[`ICN_B_GYR_EN];
         o_gyr_start <= pwr_ctrl[`ICN_B_GYR_EN] && !gyr_en_q;
         if (o_gyr_start && gain_pending)
            gain_live <= gain_new;
         o_gyr_gain <= gain_live;
      end
   end

   // Sticky error/event/status; a new event beats a clear-on-read
   logic rd_bit0;
   assign rd_bit0 = rd_ok; // Byte port always includes bit 0
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || soft_rst)
      begin
         err_reg <= 8'h00;
         event_reg <= 8'h01;
         ist0 <= 8'h00;
         ist1 <= 8'h00;
         drdy_acc <= 1'b0;
         drdy_gyr <= 1'b0;
      end
      else
      begin
         err_reg <= ((rd_bit0 && i_addr == `ICN_A_ERR) ? 8'h00 : err_reg) | i_hw_err;
         ist0 <= ((rd_bit0 && i_addr == `ICN_A_INT_STAT0) ? 8'h00 : ist0) | i_int_stat0;
         ist1 <= ((rd_bit0 && i_addr == `ICN_A_INT_STAT1) ? 8'h00 : ist1) | i_int_stat1;
         event_reg <= ((rd_bit0 && i_addr == `ICN_A_EVENT) ? 8'h00 : event_reg)
            | ((accel_config_register[3:0] == 4'h0 || gyro_config_register[3:0] < 4'h6) ? `ICN_EV_CONF_ERR : 8'h00);
         drdy_acc <= (drdy_acc && !(rd_ok && i_addr == `ICN_A_ACC_X_HI)) || i_drdy_acc;
         drdy_gyr <= (drdy_gyr && !(rd_ok && i_addr == `ICN_A_GYR_X_HI)) || i_drdy_gyr;
      end
   end

   // Error interrupt, masked and mapped
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         o_int1 <= 1'b0;
         o_int2 <= 1'b0;
      end
      else
      begin
         o_int1 <= |(err_reg & err_mask) && int_map[`ICN_B_ERR_TO_PIN1];
         o_int2 <= |(err_reg & err_mask) && int_map[`ICN_B_ERR_TO_PIN2];
      end
   end

   // Shadow freeze at the first read of a burst
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         shadow_live <= 1'b0;
      else if (!i_burst)
         shadow_live <= 1'b0;
      else if (rd_ok)
         shadow_live <= 1'b1;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (rd_ok && !shadow_live)
      begin
         for (int k = 0; k < 24; k++)
            shadow[k] <= i_sensor_data[k];
         for (int k = 0; k < 16; k++)
            shadow[24 + k] <= i_feature_data[k];
      end
   end

   // Read mux; the host's address counter holds on the port registers
   always_comb
   begin
      next_rdata = 8'h00;
      if (busy)
         next_rdata = status_byte;
      else if (i_addr == `ICN_A_STATUS)
         next_rdata = status_byte;
      else if (i_addr >= `ICN_A_DATA_FIRST && i_addr < `ICN_A_EVENT)
         next_rdata = (shadow_live ? shadow[5'(i_addr - `ICN_A_DATA_FIRST)]
            : i_sensor_data[5'(i_addr - `ICN_A_DATA_FIRST)]);
      else if (in_feat)
         next_rdata = shadow_live ? shadow[6'(24 + 6'(i_addr - `ICN_A_FEAT_FIRST))]
            : i_feature_data[4'(i_addr - `ICN_A_FEAT_FIRST)];
      else if (i_addr >= `ICN_A_NV_FIRST && i_addr <= `ICN_A_NV_LAST && i_addr != `ICN_A_CRT_CONF)
         next_rdata = nv_img[4'(i_addr - `ICN_A_NV_FIRST)];
      else
      begin
         unique case (i_addr)
            `ICN_A_ERR: next_rdata = err_reg;
            `ICN_A_EVENT: next_rdata = event_reg;
            `ICN_A_INT_STAT0: next_rdata = ist0;
            `ICN_A_INT_STAT1: next_rdata = ist1;
            `ICN_A_ERR_MASK: next_rdata = err_mask;
            `ICN_A_INT_MAP: next_rdata = int_map;
            `ICN_A_ACCEL_CONFIG_REGISTER: next_rdata = accel_config_register;
            `ICN_A_GYRO_CONFIG_REGISTER: next_rdata = gyro_config_register;
            `ICN_A_GEN_SET: next_rdata = gen_set;
            `ICN_A_GAIN_STATUS: next_rdata = {5'h00, gain_status};
            `ICN_A_G_TRIG: next_rdata = g_trig;
            `ICN_A_CRT_CONF: next_rdata = {5'h00, crt_running, 2'b00};
            `ICN_A_PWR_CONF: next_rdata = pwr_conf;
            `ICN_A_PWR_CTRL: next_rdata = pwr_ctrl;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         o_rdata <= 8'h00;
      else if (i_rd)
         o_rdata <= next_rdata;
      else
         o_rdata <= 8'h00;
   end

   logic unused_ok;
   assign unused_ok = in_main;
endmodule : icn_ctrl

// ### pkg/icn_regs.svh
/*
 Offsets, field positions, reset values and nanosecond timings of the command and NVM
 control block. Included by hw/icn_ctrl.sv; pkg/icn_pkg.sv does not include it.
 Assumes a byte-wide register port and a 100 MHz reference clock.
*/
// Summary of operation
// - Retrim end clears running flag, sets status
// - Motion aborts retrim, gain kept, status 0x03
// - Retrimmed gain applied at next gyro start
// - Retrim may be repeated any number of times
// - Reset loads NVM image; ready low meanwhile
// - Image registers read/write like ordinary registers, except 0x69, which reads back the retrim running flag
// - Program rewrites whole NVM; ready low meanwhile
// - Program starts only with autosave disabled
// - Register port dead until boot completes
// - During NVM access, drop writes except soft reset during program, reads give status
// - Masked error bits raise interrupt on mapped pins
// - Illegal sensor configuration logs event error code
// - Command 0xb6 soft-resets, reloads NVM defaults
// - Burst address increments except two port registers
// - Burst start freezes shadow of whole group
// - Error, event, interrupt status clear on read
// - Clear happens when bit 0 is read
`ifndef ICN_REGS_SVH
`define ICN_REGS_SVH

`define ICN_A_ERR 8'h02
`define ICN_A_STATUS 8'h03
`define ICN_A_DATA_FIRST 8'h04
`define ICN_A_ACC_X_HI 8'h0d
`define ICN_A_GYR_X_HI 8'h13
`define ICN_A_GRP_LAST 8'h1b
`define ICN_A_EVENT 8'h1b
`define ICN_A_INT_STAT0 8'h1c
`define ICN_A_INT_STAT1 8'h1d
`define ICN_A_STEP_FIRST 8'h1e
`define ICN_A_STEP_LAST 8'h1f
`define ICN_A_FIFO_LEN_FIRST 8'h24
`define ICN_A_FIFO_LEN_LAST 8'h25
`define ICN_A_FIFO_DATA 8'h26
`define ICN_A_FEAT_FIRST 8'h30
`define ICN_A_FEAT_LAST 8'h3f
`define ICN_A_ACCEL_CONFIG_REGISTER 8'h40
`define ICN_A_GYRO_CONFIG_REGISTER 8'h42
`define ICN_A_ERR_MASK 8'h52
`define ICN_A_INT_MAP 8'h58
`define ICN_A_INIT_DATA 8'h5e
`define ICN_A_GEN_SET 8'h60
`define ICN_A_GAIN_STATUS 8'h61
`define ICN_A_G_TRIG 8'h62
`define ICN_A_CRT_CONF 8'h69
`define ICN_A_NVM_CONF 8'h6a
`define ICN_A_NV_FIRST 8'h68
`define ICN_A_NV_LAST 8'h77
`define ICN_A_OFFSET6 8'h77
`define ICN_A_PWR_CONF 8'h7c
`define ICN_A_PWR_CTRL 8'h7d
`define ICN_A_CMD 8'h7e

`define ICN_CMD_SOFTRESET 8'hb6
`define ICN_CMD_G_TRIGGER 8'h02
`define ICN_CMD_PROG_NVM 8'ha0

`define ICN_B_CMD_RDY 4
`define ICN_B_DRDY_GYR 6
`define ICN_B_DRDY_ACC 7
`define ICN_B_CRT_RUNNING 2
`define ICN_B_NVM_PROG_EN 1
`define ICN_B_AUTOSAVE 0
`define ICN_B_GAIN_EN 7
`define ICN_B_ACC_EN 2
`define ICN_B_GYR_EN 1
`define ICN_B_NVM_PREP 4
`define ICN_B_ERR_TO_PIN1 3
`define ICN_B_ERR_TO_PIN2 7
`define ICN_B_TRIG_SELECT 0
`define ICN_B_TRIG_BLOCK 1

`define ICN_RST_PWR_CONF 8'h03
`define ICN_RST_ACCEL_CONFIG_REGISTER 8'ha8
`define ICN_RST_GYRO_CONFIG_REGISTER 8'ha9
`define ICN_GAIN_OK 3'h0
`define ICN_GAIN_ABORT 3'h3
`define ICN_GAIN_EXEC_ERR 3'h1
`define ICN_EV_CONF_ERR 8'h04

`define ICN_BOOT_NS 2000000
`define ICN_CRT_NS 500000
`define ICN_PROG_NS 10000000
`define ICN_CLK_NS 10

`endif

// ### pkg/icn_pkg.sv
/*
 Types of the command and NVM control block.
 Assumes nothing of its surroundings.
*/
package icn_pkg;
   typedef enum logic [3:0]
   {
      ICN_BOOT = 4'b0001,
      ICN_IDLE = 4'b0010,
      ICN_CRT = 4'b0100,
      ICN_PROG = 4'b1000
   } icn_state_e;
   typedef logic [7:0] icn_byte_t;
endpackage : icn_pkg

// ### sim/icn_nvm_model.sv
/*
 NVM array model for icn_ctrl: 16 bytes, read data one cycle after address.
 Assumes the block drives address, write data and write enable.
*/
`timescale 1ns/10ps
module icn_nvm_model
(
   input wire logic i_ref_clk,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_we,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [0:15];
   // Low nibble zero keeps the prog unlock and retrim bits clear after boot
   initial
   begin
      for (int k = 0; k < 16; k++)
         mem[k] = 8'(k * 16);
   end
   always @(posedge i_ref_clk)
   begin
      if (i_we)
         mem[i_addr] <= i_wdata;
      o_rdata <= mem[i_addr];
   end
endmodule : icn_nvm_model

// ### sim/icn_ctrl_properties.sv
/*
 Port assertions of icn_ctrl, bound into it.
 Assumes strobes stay low while reset is high.
*/
`timescale 1ns/10ps
module icn_ctrl_checker
#(
   parameter int BOOT_CYC = 40
)
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic [3:0] o_nvm_addr,
   input wire logic o_nvm_we,
   input wire logic o_int1,
   input wire logic o_int2,
   input wire logic o_gyr_start,
   input wire logic [10:0] o_gyr_gain
);
   int boot_cnt;
   logic sr_wr;
   logic pwr_wr;
   logic prog_wr;
   assign sr_wr = i_wr && i_addr == 8'h7e && i_wdata == 8'hb6;
   assign pwr_wr = i_wr && i_addr == 8'h7d && i_wdata[1];
   assign prog_wr = i_wr && i_addr == 8'h7e && i_wdata == 8'ha0;
   // Soft reset restarts the count, so boot checks cover it too
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || sr_wr)
         boot_cnt <= 0;
      else if (boot_cnt < BOOT_CYC)
         boot_cnt <= boot_cnt + 1;
   end
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);
   a_rdata_idle_zero:
      assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside its slot");
   a_boot_status:
      assert property (boot_cnt < BOOT_CYC && i_rd |=> o_rdata[4] == 1'b0)
      else $error("ready seen during boot");
   a_boot_no_write:
      assert property (boot_cnt < BOOT_CYC |-> !o_nvm_we)
      else $error("nvm write during boot");
   a_boot_int_quiet:
      assert property (boot_cnt < BOOT_CYC |-> !(o_int1 || o_int2))
      else $error("interrupt during boot");
   a_start_pulse:
      assert property (o_gyr_start |=> !o_gyr_start)
      else $error("gyro start too long");
   a_start_cause:
      assert property (o_gyr_start |-> $past(pwr_wr) || $past(pwr_wr, 2) || $past(pwr_wr, 3))
      else $error("gyro start without enable");
   a_gain_hold:
      assert property (!o_gyr_start && !$past(o_gyr_start, 2) && !$past(sr_wr)
         |-> $stable(o_gyr_gain))
      else $error("gain moved without gyro start");
   a_prog_cause:
      assert property ($rose(o_nvm_we) |-> $past(prog_wr) || $past(prog_wr, 2)
         || $past(prog_wr, 3))
      else $error("nvm write without command");
   a_nvm_addr_step:
      assert property (o_nvm_we && $past(o_nvm_we) |-> o_nvm_addr == $past(o_nvm_addr) + 4'h1)
      else $error("nvm address skipped");
   c_gyro_start: cover property (o_gyr_start);
   c_nvm_write: cover property ($rose(o_nvm_we));
   c_int_both: cover property (o_int1 && o_int2);
endmodule : icn_ctrl_checker

bind icn_ctrl icn_ctrl_checker #(.BOOT_CYC(BOOT_CYC)) chk_u
(
   .i_ref_clk,
   .i_rst,
   .i_addr,
   .i_wdata,
   .i_wr,
   .i_rd,
   .o_rdata,
   .o_nvm_addr,
   .o_nvm_we,
   .o_int1,
   .o_int2,
   .o_gyr_start,
   .o_gyr_gain
);

// ### sim/tb.sv
/*
 Bench of icn_ctrl: register tasks, scenarios and verdict.
 Assumes icn_nvm_model as NVM and shortened boot, program and retrim counts.
*/
`timescale 1ns/10ps
module tb;
   logic i_ref_clk, i_rst, i_wr, i_rd, i_burst, i_motion, i_crt_fail, i_drdy_acc, i_drdy_gyr;
   logic [7:0] i_addr, i_wdata, i_nvm_rdata, i_hw_err, i_int_stat0, i_int_stat1, o_rdata;
   logic [7:0] i_sensor_data [0:23];
   logic [7:0] i_feature_data [0:15];
   logic [10:0] i_crt_gain, o_gyr_gain, exp_g;
   logic [3:0] o_nvm_addr;
   logic [7:0] o_nvm_wdata;
   logic o_nvm_we, o_int1, o_int2, o_gyr_start;
   logic [1:0] crt_in [0:3] = '{2'h0, 2'h2, 2'h1, 2'h0};
   logic [10:0] crt_gain_tab [0:3] = '{11'h4a5, 11'h311, 11'h4a5, 11'h5c3};
   logic [7:0] crt_st [0:3] = '{8'h00, 8'h03, 8'h01, 8'h00};
   int n_mismatch = 0;
   int total_checks = 0;
   icn_ctrl #(.BOOT_CYC(40), .PROG_CYC(40), .CRT_CYC(20)) dut_u
   (
      .i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .i_burst,
      .i_nvm_rdata, .i_sensor_data, .i_feature_data, .i_motion, .i_crt_fail,
      .i_hw_err, .i_int_stat0, .i_int_stat1, .i_drdy_acc, .i_drdy_gyr, .i_crt_gain,
      .o_rdata, .o_nvm_addr, .o_nvm_wdata, .o_nvm_we, .o_int1, .o_int2,
      .o_gyr_start, .o_gyr_gain
   );
   icn_nvm_model nvm_u
   (
      .i_ref_clk,
      .i_addr(o_nvm_addr),
      .i_wdata(o_nvm_wdata),
      .i_we(o_nvm_we),
      .o_rdata(i_nvm_rdata)
   );
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
      // One idle edge keeps back-to-back calls from assigning the strobe twice
      @(posedge i_ref_clk);
   endtask : wr_reg
   // Data is taken 1 ns after the edge that samples the strobe, after the strobe has dropped
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
      @(posedge i_ref_clk);
   endtask : rd_reg
   task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd_reg(a, d);
      chk(n, 11'(e), 11'(d));
   endtask : rc
   task automatic poll(input logic [7:0] a, input int b, input logic v);
      logic [7:0] d;
      int k;
      for (k = 0; k < 200; k++)
      begin
         rd_reg(a, d);
         if (d[b] === v)
            break;
      end
      if (k == 200)
      begin
         n_mismatch++;
         print_verdict();
      end
   endtask : poll
   initial
   begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   initial
   begin
      {i_wr, i_rd, i_burst, i_motion, i_crt_fail, i_drdy_acc, i_drdy_gyr} = 7'h00;
      {i_addr, i_wdata, i_hw_err, i_int_stat0, i_int_stat1} = 40'h0;
      i_crt_gain = 11'h400;
      i_rst = 1'b1;
      for (int k = 0; k < 24; k++)
         i_sensor_data[k] = 8'h30 + 8'(k);
      for (int k = 0; k < 16; k++)
         i_feature_data[k] = 8'h00;
      repeat (5) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      rc("boot read", 8'h40, 8'h00);
      wr_reg(8'h40, 8'h00);
      poll(8'h03, 4, 1'b1);
      rc("accel_config_register", 8'h40, 8'ha8);
      rc("image", 8'h70, 8'h80);
      wr_reg(8'h71, 8'h5a);
      rc("image rw", 8'h71, 8'h5a);
      wr_reg(8'h52, 8'h01);
      wr_reg(8'h58, 8'h88);
      i_hw_err <= 8'h03;
      i_int_stat0 <= 8'h21;
      @(posedge i_ref_clk);
      i_hw_err <= 8'h00;
      i_int_stat0 <= 8'h00;
      repeat (3) @(posedge i_ref_clk);
      chk("int pins", 11'h3, 11'({o_int1, o_int2}));
      wr_reg(8'h58, 8'h08);
      repeat (3) @(posedge i_ref_clk);
      chk("int map", 11'h2, 11'({o_int1, o_int2}));
      rc("err", 8'h02, 8'h03);
      rc("err cleared", 8'h02, 8'h00);
      chk("int off", 11'h0, 11'({o_int1, o_int2}));
      i_hw_err <= 8'h02;
      @(posedge i_ref_clk);
      i_hw_err <= 8'h00;
      repeat (3) @(posedge i_ref_clk);
      chk("int masked", 11'h0, 11'({o_int1, o_int2}));
      rc("int stat", 8'h1c, 8'h21);
      rc("int stat cleared", 8'h1c, 8'h00);
      rc("event", 8'h1b, 8'h01);
      rc("event cleared", 8'h1b, 8'h00);
      wr_reg(8'h40, 8'ha0);
      wr_reg(8'h40, 8'ha8);
      rc("event conf", 8'h1b, 8'h04);
      i_burst <= 1'b1;
      rc("burst first", 8'h04, 8'h30);
      i_sensor_data[1] <= 8'h99;
      rc("burst frozen", 8'h05, 8'h31);
      i_burst <= 1'b0;
      @(posedge i_ref_clk);
      rc("burst over", 8'h05, 8'h99);
      i_drdy_acc <= 1'b1;
      i_drdy_gyr <= 1'b1;
      @(posedge i_ref_clk);
      i_drdy_acc <= 1'b0;
      i_drdy_gyr <= 1'b0;
      rc("drdy both", 8'h03, 8'hd0);
      rc("acc x hi", 8'h0d, 8'h39);
      rc("drdy gyr left", 8'h03, 8'h50);
      rc("gyr x hi", 8'h13, 8'h3f);
      rc("drdy cleared", 8'h03, 8'h10);
      wr_reg(8'h7c, 8'h00);
      repeat (45000) @(posedge i_ref_clk);
      wr_reg(8'h77, 8'h80);
      wr_reg(8'h7d, 8'h04);
      exp_g = 11'h400;
      for (int r = 0; r < 4; r++)
      begin
         {i_motion, i_crt_fail} <= crt_in[r];
         i_crt_gain <= crt_gain_tab[r];
         if (crt_st[r] == 8'h00)
            exp_g = crt_gain_tab[r];
         wr_reg(8'h69, 8'h04);
         wr_reg(8'h62, 8'h01);
         wr_reg(8'h7e, 8'h02);
         poll(8'h69, 2, 1'b0);
         rc("retrim status", 8'h61, crt_st[r]);
         i_motion <= 1'b0;
         wr_reg(8'h7d, 8'h04);
         wr_reg(8'h7d, 8'h06);
         repeat (4) @(posedge i_ref_clk);
         chk("gyro gain", exp_g, o_gyr_gain);
      end
      wr_reg(8'h7e, 8'h55);
      rc("after unknown", 8'h03, 8'h10);
      wr_reg(8'h7c, 8'h01);
      wr_reg(8'h60, 8'h10);
      // Prep wait cut short to keep the run brief
      repeat (100) @(posedge i_ref_clk);
      wr_reg(8'h6a, 8'h02);
      wr_reg(8'h7e, 8'ha0);
      rc("no program", 8'h03, 8'h10);
      wr_reg(8'h7c, 8'h00);
      wr_reg(8'h7e, 8'ha0);
      wr_reg(8'h71, 8'h77);
      rc("program busy", 8'h40, 8'h00);
      poll(8'h03, 4, 1'b1);
      rc("dropped write", 8'h71, 8'h5a);
      chk("nvm byte", 11'h5a, 11'(nvm_u.mem[9]));
      chk("nvm last", 11'h80, 11'(nvm_u.mem[15]));
      wr_reg(8'h71, 8'h11);
      wr_reg(8'h7e, 8'hb6);
      rc("soft reset", 8'h03, 8'h00);
      poll(8'h03, 4, 1'b1);
      rc("nvm default", 8'h71, 8'h5a);
      print_verdict();
   end
endmodule : tb
